// ===== core/adcss_pkg.sv
/*
  Package for the converter scan sequencer: register indices, configuration
  field positions, reset values, timing counts and the carrier structs.
  Assumes a single 125 MHz master clock domain.
*/
package adcss_pkg;

  // ****************************************************************
  // Register map (core input register space)
  // ****************************************************************
  localparam logic [3:0] ADCSS_RESULT_FIRST_IDX = 4'h1;
  localparam logic [3:0] ADCSS_RESULT_LAST_IDX  = 4'h8;
  localparam logic [3:0] ADCSS_CONF_IDX         = 4'h3;

  // ****************************************************************
  // Configuration fields
  // ****************************************************************
  localparam int ADCSS_GO_BIT      = 0;
  localparam int ADCSS_CONT_BIT    = 1;
  localparam int ADCSS_BIAS_BIT    = 2;
  localparam int ADCSS_GROUP_BIT   = 3;
  localparam int ADCSS_DIV2_BIT    = 4;
  localparam int ADCSS_FINAL_LSB   = 5;
  localparam int ADCSS_FINAL_MSB   = 7;
  localparam logic [7:0] ADCSS_CONF_RESET   = 8'h00;
  localparam logic [7:0] ADCSS_RESULT_RESET = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ADCSS_CONV_CYCLES = 82;
  localparam int ADCSS_MCLK_MHZ    = 125;
  localparam int ADCSS_BIAS_SETTLE_US = 60;
  localparam int ADCSS_BIAS_SETTLE_CYC = ADCSS_BIAS_SETTLE_US * ADCSS_MCLK_MHZ;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [2:0] final_input_index;
    logic       div2;
    logic       group_scan_select;
    logic       bias_enable;
    logic       continuous_select;
    logic       conversion_go;
  } adcss_conf_s;

  typedef struct packed {
    logic       start;
    logic [2:0] channel;
  } adcss_conv_req_s;

  typedef struct packed {
    logic       done;
    logic [7:0] data;
  } adcss_conv_rsp_s;

endpackage : adcss_pkg

// ===== core/adcss_seq.sv
/*
  Converter scan sequencer: configuration register, channel walk, converter
  clock enable, conversion timing and the eight result holding registers.
  Assumes the analog core holds its result on conv_data by the last counted
  converter cycle; the tick count times each conversion, no done strobe is taken; reads and writes come from the core on mclk.
*/
// How it works
// - Group 0, single: convert indexed channel, pulse done, then idle.
// - Group 1, single: convert 0..index in order, one done pulse at group end.
// - Group 0, continuous: repeat indexed channel until go cleared.
// - Group 1, continuous: repeat scan 0..index until go cleared.
// - Each finished conversion overwrites its channel's result register.
// - Bias enable resets to 0 and is forced to 0 on halt.
// - Channel 0..7 results read at input addresses 1..8.
// - Bits 7:5 hold final index; scan runs from channel 0 upward.
// - Bit 4 halves the converter clock; needed above 10 MHz master.
// - Bit 3 selects single indexed channel or whole group.
// - Bit 2 powers converter; at 0 converter logic idles.
// - Bit 1 selects continuous; go starts first sequence, rest follow.
// - Bit 0 starts or stops; hardware clears it after single sequence.
// - Each conversion takes 82 converter clocks.
// - Done is one maskable interrupt source pulse.
`timescale 1ns/1ps

module adcss_seq
  import adcss_pkg::*;
#(
  parameter int CONV_CYCLES = ADCSS_CONV_CYCLES
) (
  input  wire logic                     mclk,          // Master clock
  input  wire logic                     srst,          // Sync reset, high
  input  wire logic                     halt,          // Core in halt state
  input  wire logic                     conf_wr,       // Config write strobe
  input  wire logic [7:0]               conf_wdata,    // Config write data
  output logic [7:0]                    conf_rdata,    // Config readback
  input  wire logic [3:0]               rd_index,      // Input register index
  output logic [7:0]                    rd_data,       // Result read data
  output logic                          rd_hit,        // Index maps a result
  input  wire logic [7:0]               conv_data,     // Converter core result
  output adcss_pkg::adcss_conv_req_s    conv_req,      // Mux select and start
  output logic                          conv_clk_en,   // Converter clock enable
  output logic                          analog_power,  // Bias and analog power
  output logic                          conv_done_irq, // End of sequence pulse
  output logic                          busy           // Sequence running
);
  import adcss_pkg::*;

  // The tick counter is 8 bits wide, so longer conversions cannot be counted
  if (CONV_CYCLES < 2 || CONV_CYCLES > 255) begin : g_bad_cycles
    $error("CONV_CYCLES out of range");
  end

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  adcss_conf_s conf;
  logic        seq_end;
  logic        abort_go;
  adcss_conf_s wr_conf;

  assign wr_conf = adcss_conf_s'(conf_wdata);

  always_ff @(posedge mclk) begin
    if (srst) begin
      conf <= adcss_conf_s'(ADCSS_CONF_RESET);
    end else begin
      if (conf_wr) begin
        conf <= wr_conf;
      end
      // Hardware clear in single mode; a simultaneous write wins only if it re-arms
      if (seq_end && !conf.continuous_select && !(conf_wr && wr_conf.conversion_go)) begin
        conf.conversion_go <= 1'b0;
      end
      if (halt) begin
        conf.bias_enable <= 1'b0;
      end
    end
  end

  assign conf_rdata   = conf;
  assign analog_power = conf.bias_enable;

  // ****************************************************************
  // Converter clock enable
  // ****************************************************************
  logic div_tog;

  always_ff @(posedge mclk) begin
    if (srst || !conf.bias_enable) begin
      div_tog <= 1'b0;
    end else begin
      div_tog <= ~div_tog;
    end
  end

  assign conv_clk_en = conf.bias_enable && (!conf.div2 || div_tog);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    ADCSS_IDLE = 2'b00,
    ADCSS_CONV = 2'b01,
    ADCSS_NEXT = 2'b10
  } adcss_state_e;

  adcss_state_e state;
  adcss_state_e next_state;
  logic [2:0]   chan;
  logic [2:0]   next_chan;
  logic [7:0]   tick;
  logic         run_ok;
  logic         conv_end;
  logic         last_chan;
  logic [2:0]   first_chan;

  assign run_ok     = conf.conversion_go && conf.bias_enable && !halt;
  assign abort_go   = !run_ok;
  assign conv_end   = (state == ADCSS_CONV) && conv_clk_en &&
                      (tick == 8'(CONV_CYCLES - 1));
  assign first_chan = conf.group_scan_select ? 3'h0 : conf.final_input_index;
  assign last_chan  = (chan == conf.final_input_index);
  assign seq_end    = conv_end && last_chan;

  always_comb begin
    next_state = state;
    next_chan  = chan;
    case (state)
      ADCSS_IDLE: begin
        if (run_ok) begin
          next_state = ADCSS_CONV;
          next_chan  = first_chan;
        end
      end
      ADCSS_CONV: begin
        if (abort_go) begin
          next_state = ADCSS_IDLE;
        end else if (conv_end) begin
          if (!last_chan) begin
            next_state = ADCSS_NEXT;
            next_chan  = chan + 3'h1;
          end else if (conf.continuous_select) begin
            next_state = ADCSS_NEXT;
            next_chan  = first_chan;
          end else begin
            next_state = ADCSS_IDLE;
          end
        end
      end
      ADCSS_NEXT: begin
        next_state = abort_go ? ADCSS_IDLE : ADCSS_CONV;
      end
      default: begin
        next_state = ADCSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ADCSS_IDLE;
      chan  <= 3'h0;
      tick  <= 8'h00;
    end else begin
      state <= next_state;
      chan  <= next_chan;
      if (next_state != ADCSS_CONV || state != ADCSS_CONV) begin
        tick <= 8'h00;
      end else if (conv_clk_en) begin
        tick <= tick + 8'h01;
      end
    end
  end

  // Start pulses on entry to a conversion; mux select holds throughout
  always_ff @(posedge mclk) begin
    if (srst) begin
      conv_req <= '0;
    end else begin
      conv_req.start   <= (next_state == ADCSS_CONV) && (state != ADCSS_CONV);
      conv_req.channel <= next_chan;
    end
  end

  // ****************************************************************
  // End of sequence event
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      conv_done_irq <= 1'b0;
    end else begin
      conv_done_irq <= seq_end && !abort_go;
    end
  end

  assign busy = (state != ADCSS_IDLE);

  // ****************************************************************
  // Result holding registers
  // ****************************************************************
  logic [7:0] result [8];
  logic [3:0] rd_off;

  for (genvar g = 0; g < 8; g++) begin : g_res
    always_ff @(posedge mclk) begin
      if (srst) begin
        result[g] <= ADCSS_RESULT_RESET;
      end else if (conv_end && !abort_go && chan == 3'(g)) begin
        result[g] <= conv_data;
      end
    end
  end

  assign rd_off  = rd_index - ADCSS_RESULT_FIRST_IDX;
  assign rd_hit  = (rd_index >= ADCSS_RESULT_FIRST_IDX) && (rd_index <= ADCSS_RESULT_LAST_IDX);
  assign rd_data = rd_hit ? result[rd_off[2:0]] : 8'h00;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_DONE_AFTER_LAST: assert property (@(posedge mclk) disable iff (srst)
    conv_done_irq |-> $past(last_chan) && $past(state) == ADCSS_CONV)
    else $error("done without last channel");

  AST_DONE_ONE_CYCLE: assert property (@(posedge mclk) disable iff (srst)
    conv_done_irq |=> !conv_done_irq)
    else $error("done pulse too long");

  AST_SINGLE_CLEARS_GO: assert property (@(posedge mclk) disable iff (srst)
    (seq_end && !abort_go && !conf.continuous_select && !conf_wr) |=> !conf.conversion_go)
    else $error("go not cleared after single sequence");

  AST_SINGLE_STOPS: assert property (@(posedge mclk) disable iff (srst)
    (seq_end && !abort_go && !conf.continuous_select) |=> state == ADCSS_IDLE)
    else $error("single sequence did not stop");

  AST_NO_EARLY_DONE: assert property (@(posedge mclk) disable iff (srst)
    (conv_end && !abort_go && !last_chan) |=> !conv_done_irq)
    else $error("done before group end");

  AST_CONT_KEEPS_GO: assert property (@(posedge mclk) disable iff (srst)
    (seq_end && !abort_go && conf.continuous_select && !conf_wr) |=> conf.conversion_go)
    else $error("go cleared in continuous");

  AST_HALT_BIAS: assert property (@(posedge mclk) disable iff (srst)
    halt |=> !conf.bias_enable)
    else $error("bias not forced off in halt");

  AST_RESET_CONF: assert property (@(posedge mclk)
    srst |=> conf_rdata == ADCSS_CONF_RESET && state == ADCSS_IDLE)
    else $error("reset state wrong");

  AST_RESULT_WRITE: assert property (@(posedge mclk) disable iff (srst)
    (conv_end && !abort_go) |=> result[$past(chan)] == $past(conv_data))
    else $error("result not stored");

  AST_ABORT_IDLE: assert property (@(posedge mclk) disable iff (srst)
    (state == ADCSS_CONV && abort_go) |=> state == ADCSS_IDLE)
    else $error("conversion not abandoned");

  // A stop written during the gap cycle legitimately sends the walk back to idle
  AST_CONT_RESTART: assert property (@(posedge mclk) disable iff (srst)
    (seq_end && !abort_go && conf.continuous_select) |=>
      state == ADCSS_NEXT ##1 (state == ADCSS_CONV || $past(abort_go)))
    else $error("continuous did not restart");

  AST_GROUP_STEP: assert property (@(posedge mclk) disable iff (srst)
    (conv_end && !abort_go && !last_chan) |=> chan == $past(chan) + 3'h1)
    else $error("channel did not step");

  AST_START_FIRST: assert property (@(posedge mclk) disable iff (srst)
    (state == ADCSS_IDLE && run_ok) |=> conv_req.start && conv_req.channel == $past(first_chan))
    else $error("sequence started on wrong channel");

  AST_CONV_COUNTS: assert property (@(posedge mclk) disable iff (srst)
    (state == ADCSS_CONV && conv_clk_en && !conv_end && !abort_go) |=>
      state == ADCSS_CONV && tick == $past(tick) + 8'h01)
    else $error("conversion count skipped");

  AST_TICK_BOUND: assert property (@(posedge mclk) disable iff (srst)
    state == ADCSS_CONV |-> tick < 8'(CONV_CYCLES))
    else $error("conversion overran");

  AST_DIV_RATE: assert property (@(posedge mclk) disable iff (srst)
    (conf.div2 && conv_clk_en) |=> (!conv_clk_en || !conf.div2))
    else $error("divided enable too fast");

  AST_OFF_IDLE: assert property (@(posedge mclk) disable iff (srst)
    !conf.bias_enable |=> state == ADCSS_IDLE)
    else $error("converter ran unpowered");

  AST_OFF_NO_CLK: assert property (@(posedge mclk) disable iff (srst)
    !conf.bias_enable |-> !conv_clk_en)
    else $error("converter clock while unpowered");

  // Read side is checked at both ends of the map and outside it
  AST_READ_FIRST: assert property (@(posedge mclk) disable iff (srst)
    (rd_index == ADCSS_RESULT_FIRST_IDX) |-> rd_hit && rd_data == result[0])
    else $error("first result address wrong");

  AST_READ_LAST: assert property (@(posedge mclk) disable iff (srst)
    (rd_index == ADCSS_RESULT_LAST_IDX) |-> rd_hit && rd_data == result[7])
    else $error("last result address wrong");

  AST_READ_MISS: assert property (@(posedge mclk) disable iff (srst)
    (rd_index == 4'h0 || rd_index > ADCSS_RESULT_LAST_IDX) |-> !rd_hit && rd_data == 8'h00)
    else $error("read outside result map");

endmodule : adcss_seq

// ===== testbench/adcss_conv_model.sv
/*
  Behavioural converter core with its analog input multiplexer.
  Assumes the sequencer pulses conv_req.start once per conversion and holds
  conv_req.channel steady until the result has been taken; the result is
  valid only from the last of the full count of enabled converter cycles onward.
*/
`timescale 1ns/1ps

module adcss_conv_model
  import adcss_pkg::*;
#(
  parameter int CONV_CYCLES = ADCSS_CONV_CYCLES
) (
  input  wire logic                       mclk,        // Master clock
  input  wire logic                       srst,        // Sync reset, high
  input  wire adcss_pkg::adcss_conv_req_s conv_req,    // Mux select and start
  input  wire logic                       conv_clk_en, // Converter clock enable
  output logic [7:0]                      conv_data    // Conversion result
);
  import adcss_pkg::*;
  logic [4:0] conv_cnt;
  logic [7:0] en_cnt;
  logic       data_ok;
  // Result carries a running count and the channel, so stale or swapped data shows
  // Before the last enabled cycle the result reads FF, so an early latch shows too
  assign data_ok   = !conv_req.start && (en_cnt >= 8'(CONV_CYCLES - 1));
  assign conv_data = data_ok ? {conv_cnt, conv_req.channel} : 8'hFF;
  always_ff @(posedge mclk) begin
    if (srst) begin
      conv_cnt <= 5'h00;
      en_cnt   <= 8'h00;
    end else if (conv_req.start) begin
      conv_cnt <= conv_cnt + 5'h01;
      en_cnt   <= conv_clk_en ? 8'h01 : 8'h00;
    end else if (conv_clk_en && en_cnt != 8'hFF) begin
      en_cnt <= en_cnt + 8'h01;
    end
  end
endmodule : adcss_conv_model

// ===== testbench/tb.sv
/*
  Self-checking bench for the scan sequencer: configuration writes, result
  reads and waits on the end-of-sequence pulse. Assumes the converter model
  beside it and a shortened conversion count.
*/
`timescale 1ns/1ps

module tb;
  import adcss_pkg::*;
  localparam int NCYC = 8;
  logic mclk = 1'b0, srst = 1'b1, halt = 1'b0, conf_wr = 1'b0;
  logic [7:0] conf_wdata = 8'h00, conf_rdata, rd_data, conv_data;
  logic [3:0] rd_index = 4'h0;
  logic rd_hit, conv_clk_en, analog_power, conv_done_irq, busy;
  adcss_conv_req_s conv_req;
  int miscompares = 0, cmp_count = 0, dones = 0, cyc, d0;

  always #4 mclk = ~mclk;
  always @(posedge mclk) dones <= dones + int'(conv_done_irq === 1'b1);

  adcss_seq #(.CONV_CYCLES(NCYC)) u_adcss_seq (.mclk(mclk), .srst(srst), .halt(halt), .conf_wr(conf_wr),
    .conf_wdata(conf_wdata), .conf_rdata(conf_rdata), .rd_index(rd_index), .rd_data(rd_data),
    .rd_hit(rd_hit), .conv_data(conv_data), .conv_req(conv_req), .conv_clk_en(conv_clk_en),
    .analog_power(analog_power), .conv_done_irq(conv_done_irq), .busy(busy));
  adcss_conv_model #(.CONV_CYCLES(NCYC)) u_adcss_conv_model (.mclk(mclk), .srst(srst), .conv_req(conv_req),
    .conv_clk_en(conv_clk_en), .conv_data(conv_data));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] d);
    @(posedge mclk);
    conf_wr    <= 1'b1;
    conf_wdata <= d;
    @(posedge mclk);
    conf_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [7:0] exp, input logic hit);
    @(posedge mclk);
    rd_index <= idx;
    #1;
    chk(rd_data, exp, "read data");
    chk({7'h00, rd_hit}, {7'h00, hit}, "read hit");
  endtask : rd

  // Counts mclk cycles from the end of the write up to the done pulse;
  // always steps one edge first so a pulse still standing is not taken twice
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (conv_done_irq !== 1'b1 && n < 2000);
    chk({7'h00, conv_done_irq}, 8'h01, "done pulse");
  endtask : wait_done

  task automatic idle_wait(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle_wait

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    idle_wait(1);
    chk(conf_rdata, ADCSS_CONF_RESET, "conf reset");
    chk({7'h00, analog_power}, 8'h00, "power at reset");
    for (int i = 1; i <= 8; i++) rd(4'(i), ADCSS_RESULT_RESET, 1'b1);
    rd(4'h0, 8'h00, 1'b0);
    rd(4'h9, 8'h00, 1'b0);
    // Go without bias must not start anything
    wr(8'h01);
    idle_wait(3 * NCYC);
    chk({6'h00, busy, conv_clk_en}, 8'h00, "unpowered idle");
    wr(8'h04);
    idle_wait(ADCSS_BIAS_SETTLE_CYC);
    chk({7'h00, analog_power}, 8'h01, "power on");
    // Single channel 3: one conversion, go self-clears
    wr(8'h65);
    wait_done(cyc);
    chk(8'(cyc >= NCYC && cyc <= NCYC + 4), 8'h01, "single time");
    idle_wait(2);
    chk(conf_rdata, 8'h64, "go cleared");
    rd(4'h4, 8'h0B, 1'b1);
    rd(4'h1, 8'h00, 1'b1);
    // Group 0..2, halved clock, one done for the group
    d0 = dones;
    wr(8'h5D);
    wait_done(cyc);
    chk(8'(cyc >= 6 * NCYC && cyc <= 6 * NCYC + 12), 8'h01, "div2 time");
    idle_wait(3 * NCYC);
    chk(8'(dones - d0), 8'h01, "one done per group");
    rd(4'h1, 8'h10, 1'b1);
    rd(4'h2, 8'h19, 1'b1);
    rd(4'h3, 8'h22, 1'b1);
    rd(4'h4, 8'h0B, 1'b1);
    // Abandon a conversion on channel 5
    d0 = dones;
    wr(8'hA5);
    idle_wait(NCYC / 2);
    wr(8'hA4);
    idle_wait(3 * NCYC);
    chk({7'h00, busy}, 8'h00, "abort idle");
    chk(8'(dones - d0), 8'h00, "abort no done");
    rd(4'h6, 8'h00, 1'b1);
    // Continuous group 0..1 runs until go is written 0
    wr(8'h2F);
    wait_done(cyc);
    d0 = dones;
    wait_done(cyc);
    idle_wait(1);
    chk(8'(dones - d0), 8'h02, "sequence repeats");
    wr(8'h2E);
    idle_wait(3 * NCYC);
    chk({7'h00, busy}, 8'h00, "continuous stopped");
    d0 = dones;
    idle_wait(3 * NCYC);
    chk(8'(dones - d0), 8'h00, "no done after stop");
    // Third pass was cut on channel 0, so both hold the second pass
    rd(4'h1, 8'h40, 1'b1);
    chk(8'(rd_data != 8'h10), 8'h01, "ch0 overwritten");
    rd(4'h2, 8'h49, 1'b1);
    rd(4'h3, 8'h22, 1'b1);
    // Continuous single channel 6, then halt drops bias
    wr(8'hC7);
    wait_done(cyc);
    idle_wait(1);
    wait_done(cyc);
    @(posedge mclk);
    halt <= 1'b1;
    idle_wait(2);
    chk({7'h00, analog_power}, 8'h00, "halt bias off");
    chk(conf_rdata & 8'h04, 8'h00, "halt clears bias bit");
    idle_wait(3 * NCYC);
    chk({6'h00, busy, conv_clk_en}, 8'h00, "halt idle");
    rd(4'h7, 8'h66, 1'b1);
    @(posedge mclk);
    halt <= 1'b0;
    end_of_test();
  end
endmodule : tb
